// *** hdl/tocu_top.sv ***
`timescale 1ns/1ps
module tocu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer1_ext_tick,
  input  wire logic        adc_enable,
  output logic             adc_start,
  output logic             compare_output_pin_out,
  output logic             compare_output_pin_oe,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0]  interrupt_control;
  logic [7:0]  peripheral_irq_flags;
  logic [7:0]  peripheral_irq_enables;
  logic [5:0]  timer1_control;
  logic [15:0] compare_value;
  logic [5:0]  compare_unit_control;
  logic [7:0]  port_c_direction;

  logic        setup_phase;
  logic        write_strobe;
  logic        mapped;
  logic        match_event;
  logic        pin_level;
  logic        force_low;
  logic [7:0]  next_flags;
  logic [7:0]  read_value;

  tocu_timer_if tif ();

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic logic tocu_hit(input logic [11:0] addr, input logic [9:0] idx);
    tocu_hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx);
  endfunction : tocu_hit

  function automatic logic tocu_known(input logic [11:0] addr);
    tocu_known = tocu_hit(addr, tocu_pkg::IDX_INTERRUPT_CONTROL)
              || tocu_hit(addr, tocu_pkg::IDX_IRQ_FLAGS)
              || tocu_hit(addr, tocu_pkg::IDX_COUNT_LOW)
              || tocu_hit(addr, tocu_pkg::IDX_COUNT_HIGH)
              || tocu_hit(addr, tocu_pkg::IDX_TIMER1_CONTROL)
              || tocu_hit(addr, tocu_pkg::IDX_VALUE_LOW)
              || tocu_hit(addr, tocu_pkg::IDX_VALUE_HIGH)
              || tocu_hit(addr, tocu_pkg::IDX_UNIT_CONTROL)
              || tocu_hit(addr, tocu_pkg::IDX_PORT_C_DIRECTION)
              || tocu_hit(addr, tocu_pkg::IDX_IRQ_ENABLES);
  endfunction : tocu_known

  function automatic logic tocu_wr(input logic strobe, input logic [11:0] addr,
                                   input logic [9:0] idx);
    tocu_wr = strobe && tocu_hit(addr, idx);
  endfunction : tocu_wr

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle.

  always_comb begin
    setup_phase  = psel && !penable;
    mapped       = tocu_known(paddr);
    write_strobe = psel && penable && pwrite && mapped;
    pready       = 1'b1;
    pslverr      = psel && penable && !mapped;
  end

  always_comb begin
    read_value = 8'h00;
    if (tocu_hit(paddr, tocu_pkg::IDX_INTERRUPT_CONTROL)) begin
      read_value = interrupt_control;
    end else if (tocu_hit(paddr, tocu_pkg::IDX_IRQ_FLAGS)) begin
      read_value = peripheral_irq_flags;
    end else if (tocu_hit(paddr, tocu_pkg::IDX_COUNT_LOW)) begin
      read_value = tif.count[7:0];
    end else if (tocu_hit(paddr, tocu_pkg::IDX_COUNT_HIGH)) begin
      read_value = tif.count[15:8];
    end else if (tocu_hit(paddr, tocu_pkg::IDX_TIMER1_CONTROL)) begin
      read_value = {2'b00, timer1_control};
    end else if (tocu_hit(paddr, tocu_pkg::IDX_VALUE_LOW)) begin
      read_value = compare_value[7:0];
    end else if (tocu_hit(paddr, tocu_pkg::IDX_VALUE_HIGH)) begin
      read_value = compare_value[15:8];
    end else if (tocu_hit(paddr, tocu_pkg::IDX_UNIT_CONTROL)) begin
      read_value = {2'b00, compare_unit_control};
    end else if (tocu_hit(paddr, tocu_pkg::IDX_PORT_C_DIRECTION)) begin
      read_value = port_c_direction;
    end else if (tocu_hit(paddr, tocu_pkg::IDX_IRQ_ENABLES)) begin
      read_value = peripheral_irq_enables;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {24'h000000, read_value};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control <= tocu_pkg::RST_INTERRUPT_CONTROL;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_INTERRUPT_CONTROL)) begin
      interrupt_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enables <= tocu_pkg::RST_IRQ_ENABLES;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_IRQ_ENABLES)) begin
      peripheral_irq_enables <= pwdata[7:0] & tocu_pkg::IRQ_IMPLEMENTED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_control <= tocu_pkg::RST_TIMER1_CONTROL;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_TIMER1_CONTROL)) begin
      timer1_control <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= tocu_pkg::RST_VALUE;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_VALUE_LOW)) begin
      compare_value[7:0] <= pwdata[7:0];
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_VALUE_HIGH)) begin
      compare_value[15:8] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_unit_control <= tocu_pkg::RST_UNIT_CONTROL;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_UNIT_CONTROL)) begin
      compare_unit_control <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_direction <= tocu_pkg::RST_PORT_C_DIRECTION;
    end else if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_PORT_C_DIRECTION)) begin
      port_c_direction <= pwdata[7:0];
    end
  end

  // A zero written to the whole control register drops the output latch.
  assign force_low = tocu_wr(write_strobe, paddr, tocu_pkg::IDX_UNIT_CONTROL)
                     && (pwdata[7:0] == 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: write one to clear, a hardware set wins over the clear.

  always_comb begin
    next_flags = peripheral_irq_flags;
    if (tocu_wr(write_strobe, paddr, tocu_pkg::IDX_IRQ_FLAGS)) begin
      next_flags = next_flags & ~pwdata[7:0];
    end
    if (match_event) begin
      next_flags[tocu_pkg::BIT_COMPARE_FLAG] = 1'b1;
    end
    if (tif.overflow) begin
      next_flags[tocu_pkg::BIT_TIMER1_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_flags <= tocu_pkg::RST_IRQ_FLAGS;
    end else begin
      peripheral_irq_flags <= next_flags & tocu_pkg::IRQ_IMPLEMENTED;
    end
  end

  // The compare interrupt only leaves the block when it is enabled.
  assign irq = |(peripheral_irq_flags & peripheral_irq_enables);

  ////////////////////////////////////////////////////////////////////////////////
  // Timer1 and compare unit.

  // Counting stays in the core clock domain whatever the sync select says.
  always_comb begin
    tif.run        = timer1_control[tocu_pkg::BIT_TIMER1_ON];
    tif.ext_select = timer1_control[tocu_pkg::BIT_TIMER1_EXT];
    tif.prescale   = timer1_control[tocu_pkg::BIT_PRESCALE_LO +: 2];
    tif.ext_tick   = timer1_ext_tick;
    tif.load_low   = tocu_wr(write_strobe, paddr, tocu_pkg::IDX_COUNT_LOW);
    tif.load_high  = tocu_wr(write_strobe, paddr, tocu_pkg::IDX_COUNT_HIGH);
    tif.load_data  = pwdata[7:0];
  end

  tocu_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.timer)
  );

  tocu_compare u_compare (
    .pclk               (pclk),
    .presetn            (presetn),
    .tif                (tif.cmp),
    .compare_value      (compare_value),
    .compare_mode_field (compare_unit_control[3:0]),
    .force_low          (force_low),
    .adc_enable         (adc_enable),
    .match_event        (match_event),
    .pin_level          (pin_level),
    .adc_start          (adc_start)
  );

  // The pin drives only once software has made it an output.
  assign compare_output_pin_out = pin_level;
  assign compare_output_pin_oe  = !port_c_direction[tocu_pkg::BIT_COMPARE_PIN];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_match_equal: assert property (@(posedge pclk) disable iff (!presetn)
    match_event |-> (tif.count == compare_value) && !$past(tif.count == compare_value)
                    || $past(!presetn))
    else $error("Match without fresh equality.");

  a_match_needs_mode: assert property (@(posedge pclk) disable iff (!presetn)
    match_event |-> compare_unit_control[3:2] == 2'b10)
    else $error("Match outside compare modes.");

  a_flag_on_match: assert property (@(posedge pclk) disable iff (!presetn)
    match_event |=> peripheral_irq_flags[tocu_pkg::BIT_COMPARE_FLAG])
    else $error("Compare flag not set on match.");

  a_pin_set_high: assert property (@(posedge pclk) disable iff (!presetn)
    match_event && compare_unit_control[3:0] == tocu_pkg::MODE_SET_HIGH && !force_low
    |=> compare_output_pin_out)
    else $error("Pin not driven high on match.");

  a_pin_set_low: assert property (@(posedge pclk) disable iff (!presetn)
    match_event && compare_unit_control[3:0] == tocu_pkg::MODE_SET_LOW
    |=> !compare_output_pin_out)
    else $error("Pin not driven low on match.");

  a_soft_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    match_event && compare_unit_control[3:0] == tocu_pkg::MODE_SOFT_IRQ && !force_low
    |=> $stable(compare_output_pin_out))
    else $error("Pin moved in software interrupt mode.");

  a_special_clear: assert property (@(posedge pclk) disable iff (!presetn)
    match_event && compare_unit_control[3:0] == tocu_pkg::MODE_SPECIAL
    && !tif.load_low && !tif.load_high |=> tif.count == 16'h0000)
    else $error("Special event did not clear timer1.");

  a_adc_start: assert property (@(posedge pclk) disable iff (!presetn)
    tif.clear |=> adc_start == $past(adc_enable))
    else $error("Conversion start wrong on special event.");

  a_no_t1_flag: assert property (@(posedge pclk) disable iff (!presetn)
    tif.clear && !peripheral_irq_flags[tocu_pkg::BIT_TIMER1_FLAG]
    |=> !peripheral_irq_flags[tocu_pkg::BIT_TIMER1_FLAG])
    else $error("Special event set the timer1 flag.");

  a_force_low: assert property (@(posedge pclk) disable iff (!presetn)
    force_low |=> !compare_output_pin_out ##1 !compare_output_pin_out || match_event)
    else $error("Zero control write left pin high.");

  a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && tocu_hit(paddr, tocu_pkg::IDX_COUNT_LOW)
    |=> prdata[7:0] == $past(tif.count[7:0]))
    else $error("Count low byte read wrong.");

  a_match_once: assert property (@(posedge pclk) disable iff (!presetn)
    match_event |=> !match_event)
    else $error("Match repeated on one equality.");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    tocu_wr(write_strobe, paddr, tocu_pkg::IDX_IRQ_FLAGS)
    && pwdata[tocu_pkg::BIT_COMPARE_FLAG] && !match_event
    |=> !peripheral_irq_flags[tocu_pkg::BIT_COMPARE_FLAG])
    else $error("Compare flag not cleared by a written one.");

  a_pin_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(compare_output_pin_out) |-> $past(match_event || force_low))
    else $error("Pin moved without match or zero write.");

  a_idle_mode_pin: assert property (@(posedge pclk) disable iff (!presetn)
    compare_unit_control[3:2] != 2'b10 && !force_low
    |=> $stable(compare_output_pin_out))
    else $error("Pin moved outside compare modes.");

  a_clear_mode: assert property (@(posedge pclk) disable iff (!presetn)
    tif.clear |-> compare_unit_control[3:0] == tocu_pkg::MODE_SPECIAL)
    else $error("Timer1 cleared outside special event mode.");

  a_overflow_flag: assert property (@(posedge pclk) disable iff (!presetn)
    tif.overflow |=> peripheral_irq_flags[tocu_pkg::BIT_TIMER1_FLAG])
    else $error("Timer1 rollover did not set its flag.");

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tif.run && !tif.clear && !tif.load_low && !tif.load_high
    |=> $stable(tif.count))
    else $error("Timer1 count moved while stopped.");

  a_load_low: assert property (@(posedge pclk) disable iff (!presetn)
    tif.load_low |=> tif.count[7:0] == $past(tif.load_data))
    else $error("Count low byte write lost.");

  a_load_high: assert property (@(posedge pclk) disable iff (!presetn)
    tif.load_high |=> tif.count[15:8] == $past(tif.load_data))
    else $error("Count high byte write lost.");

  a_value_low: assert property (@(posedge pclk) disable iff (!presetn)
    tocu_wr(write_strobe, paddr, tocu_pkg::IDX_VALUE_LOW)
    |=> compare_value[7:0] == $past(pwdata[7:0]))
    else $error("Compare value low byte write lost.");

  a_value_high: assert property (@(posedge pclk) disable iff (!presetn)
    tocu_wr(write_strobe, paddr, tocu_pkg::IDX_VALUE_HIGH)
    |=> compare_value[15:8] == $past(pwdata[7:0]))
    else $error("Compare value high byte write lost.");

  a_adc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |=> !adc_start)
    else $error("Conversion start longer than one cycle.");

  a_adc_cause: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |-> $past(tif.clear && adc_enable))
    else $error("Conversion start without special event.");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    peripheral_irq_enables == 8'h00 |-> !irq)
    else $error("Interrupt raised while all enables are off.");

endmodule : tocu_top

// *** hdl/tocu_pkg.sv ***
package tocu_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00B;
  localparam logic [9:0] IDX_IRQ_FLAGS         = 10'h00C;
  localparam logic [9:0] IDX_COUNT_LOW         = 10'h00E;
  localparam logic [9:0] IDX_COUNT_HIGH        = 10'h00F;
  localparam logic [9:0] IDX_TIMER1_CONTROL    = 10'h010;
  localparam logic [9:0] IDX_VALUE_LOW         = 10'h015;
  localparam logic [9:0] IDX_VALUE_HIGH        = 10'h016;
  localparam logic [9:0] IDX_UNIT_CONTROL      = 10'h017;
  localparam logic [9:0] IDX_PORT_C_DIRECTION  = 10'h087;
  localparam logic [9:0] IDX_IRQ_ENABLES       = 10'h08C;

  // Reset values.
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS         = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES       = 8'h00;
  localparam logic [5:0] RST_TIMER1_CONTROL    = 6'h00;
  localparam logic [5:0] RST_UNIT_CONTROL      = 6'h00;
  localparam logic [7:0] RST_PORT_C_DIRECTION  = 8'hFF;
  localparam logic [15:0] RST_COUNT            = 16'h0000;
  localparam logic [15:0] RST_VALUE            = 16'h0000;

  // Field positions.
  localparam int BIT_TIMER1_FLAG  = 0;
  localparam int BIT_COMPARE_FLAG = 2;
  localparam int BIT_TIMER1_ON    = 0;
  localparam int BIT_TIMER1_EXT   = 1;
  localparam int BIT_TIMER1_ASYNC = 2;
  localparam int BIT_PRESCALE_LO  = 4;
  localparam int BIT_COMPARE_PIN  = 2;
  localparam logic [7:0] IRQ_IMPLEMENTED = 8'h05;

  // Compare mode codes.
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW  = 4'h9;
  localparam logic [3:0] MODE_SOFT_IRQ = 4'hA;
  localparam logic [3:0] MODE_SPECIAL  = 4'hB;

endpackage : tocu_pkg

// *** hdl/tocu_timer_if.sv ***
`timescale 1ns/1ps
interface tocu_timer_if;
  logic [15:0] count;
  logic        clear;
  logic        overflow;
  logic        load_low;
  logic        load_high;
  logic [7:0]  load_data;
  logic        run;
  logic        ext_select;
  logic [1:0]  prescale;
  logic        ext_tick;

  modport timer (input clear, load_low, load_high, load_data, run, ext_select, prescale,
                 ext_tick, output count, overflow);
  modport cmp (input count, output clear);
  modport host (input count, overflow, output load_low, load_high, load_data, run,
                ext_select, prescale, ext_tick);
endinterface : tocu_timer_if

// *** hdl/tocu_timer.sv ***
`timescale 1ns/1ps
module tocu_timer (
  input wire logic  pclk,
  input wire logic  presetn,
  tocu_timer_if.timer tif
);

  logic [2:0]  prescale_count;
  logic        tick;
  logic        step;
  logic [2:0]  prescale_last;

  always_comb begin
    prescale_last = 3'((4'h1 << tif.prescale) - 4'h1);
    tick          = tif.ext_select ? tif.ext_tick : 1'b1;
    step          = tif.run && tick && (prescale_count == prescale_last);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 3'h0;
    end else if (!tif.run || tif.clear) begin
      prescale_count <= 3'h0;
    end else if (tick) begin
      prescale_count <= (prescale_count == prescale_last) ? 3'h0 : 3'(prescale_count + 3'h1);
    end
  end

  // A software load wins over the compare clear, which wins over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.count <= tocu_pkg::RST_COUNT;
    end else if (tif.load_low) begin
      tif.count[7:0] <= tif.load_data;
    end else if (tif.load_high) begin
      tif.count[15:8] <= tif.load_data;
    end else if (tif.clear) begin
      tif.count <= tocu_pkg::RST_COUNT;
    end else if (step) begin
      tif.count <= 16'(tif.count + 16'h0001);
    end
  end

  // Only a natural rollover reports overflow.
  assign tif.overflow = step && !tif.clear && !tif.load_low && !tif.load_high
                        && (tif.count == 16'hFFFF);

endmodule : tocu_timer

// *** hdl/tocu_compare.sv ***
`timescale 1ns/1ps
module tocu_compare (
  input wire logic  pclk,
  input wire logic  presetn,
  tocu_timer_if.cmp tif,
  input wire logic [15:0] compare_value,
  input wire logic [3:0]  compare_mode_field,
  input wire logic        force_low,
  input wire logic        adc_enable,
  output logic            match_event,
  output logic            pin_level,
  output logic            adc_start
);

  logic equal;
  logic equal_q;
  logic active;

  always_comb begin
    equal  = (tif.count == compare_value);
    active = (compare_mode_field[3:2] == 2'b10);
    match_event = active && equal && !equal_q;
    tif.clear   = match_event && (compare_mode_field == tocu_pkg::MODE_SPECIAL);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      equal_q <= 1'b0;
    end else begin
      equal_q <= equal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= 1'b0;
    end else if (force_low) begin
      pin_level <= 1'b0;
    end else if (match_event && compare_mode_field == tocu_pkg::MODE_SET_HIGH) begin
      pin_level <= 1'b1;
    end else if (match_event && compare_mode_field == tocu_pkg::MODE_SET_LOW) begin
      pin_level <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= tif.clear && adc_enable;
    end
  end

endmodule : tocu_compare

// *** dv/tocu_pin_load.sv ***
`timescale 1ns/1ps
module tocu_pin_load (
  input wire logic pclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic     pin_level
);
  logic last = 1'b0;

  // The pin has no pull, so an undriven wire shows the inverse of the last driven level.
  always_ff @(posedge pclk) begin
    if (pin_oe) begin
      last <= pin_out;
    end
  end

  assign pin_level = pin_oe ? pin_out : ~last;
endmodule : tocu_pin_load

// *** dv/test_timer1_output_compare_unit.sv ***
`timescale 1ns/1ps
module test_timer1_output_compare_unit;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic        ext_tick   = 1'b0;
  logic        adc_enable = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        adc_start;
  logic        pin_out;
  logic        pin_oe;
  logic        irq;
  logic        pin_level;
  logic [32:0] exp_q[$];
  int          err_count   = 0;
  int          checks_done = 0;
  int          adc_seen    = 0;
  int          ext_seen    = 0;
  logic        t1_ext_run  = 1'b0;

  always #20 pclk = ~pclk;

  tocu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                  .pready(pready), .pslverr(pslverr), .timer1_ext_tick(ext_tick),
                  .adc_enable(adc_enable), .adc_start(adc_start),
                  .compare_output_pin_out(pin_out), .compare_output_pin_oe(pin_oe),
                  .irq(irq));

  tocu_pin_load i_load (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
                        .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////////////

  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Read results are compared at the edge that completes the access.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        check("read queue", 33'h0, 33'h1FFFFFFFF);
      end else begin
        check("read data", exp_q.pop_front(), {pslverr, prdata});
      end
    end
    if (adc_start === 1'b1) begin
      adc_seen++;
    end
    // External ticks count only at edges where timer1 already runs on them.
    if (t1_ext_run && ext_tick === 1'b1) begin
      ext_seen++;
    end
    if (psel && penable && pwrite && paddr == {tocu_pkg::IDX_TIMER1_CONTROL, 2'b00}) begin
      t1_ext_run = (pwdata[1:0] == 2'b11);
    end
  end

  always @(posedge pclk) begin
    ext_tick <= 1'($urandom);
  end

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wdata,
                     input logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wdata};
    if (!wr) begin
      exp_q.push_back(exp);
    end
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] data);
    apb(1'b1, idx, data, 33'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] data);
    apb(1'b0, idx, 8'h00, {25'h0, data});
  endtask : rd

  // Loads the count five below the compare value and lets the timer run past it.
  task automatic run_mode(input logic [3:0] mode, input logic [15:0] value);
    logic [15:0] start;
    start = value - 16'h0005;
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h00);
    wr(tocu_pkg::IDX_COUNT_LOW, start[7:0]);
    wr(tocu_pkg::IDX_COUNT_HIGH, start[15:8]);
    wr(tocu_pkg::IDX_VALUE_LOW, value[7:0]);
    wr(tocu_pkg::IDX_VALUE_HIGH, value[15:8]);
    wr(tocu_pkg::IDX_UNIT_CONTROL, {4'h0, mode});
    wr(tocu_pkg::IDX_IRQ_FLAGS, 8'h05);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h01);
    repeat (12) @(posedge pclk);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h00);
    @(negedge pclk);
  endtask : run_mode

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    logic [3:0]  modes [6];
    logic [15:0] value;
    logic        exp_pin;
    logic        exp_flag;
    modes = '{4'h8, 4'hA, 4'h9, 4'h8, 4'hB, 4'hC};
    void'($urandom(32'h906F));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("pin enable", 33'h0, 33'(pin_oe));
    rd(tocu_pkg::IDX_IRQ_FLAGS, tocu_pkg::RST_IRQ_FLAGS);
    rd(tocu_pkg::IDX_IRQ_ENABLES, tocu_pkg::RST_IRQ_ENABLES);
    rd(tocu_pkg::IDX_UNIT_CONTROL, 8'h00);
    rd(tocu_pkg::IDX_TIMER1_CONTROL, 8'h00);
    rd(tocu_pkg::IDX_PORT_C_DIRECTION, tocu_pkg::RST_PORT_C_DIRECTION);
    apb(1'b0, 10'h001, 8'h00, {1'b1, 32'h0});
    wr(tocu_pkg::IDX_PORT_C_DIRECTION, 8'hFB);
    rd(tocu_pkg::IDX_PORT_C_DIRECTION, 8'hFB);
    @(negedge pclk);
    check("pin enable", 33'h1, 33'(pin_oe));
    wr(tocu_pkg::IDX_COUNT_LOW, 8'h34);
    wr(tocu_pkg::IDX_COUNT_HIGH, 8'h12);
    rd(tocu_pkg::IDX_COUNT_LOW, 8'h34);
    rd(tocu_pkg::IDX_COUNT_HIGH, 8'h12);
    wr(tocu_pkg::IDX_IRQ_ENABLES, 8'h04);
    rd(tocu_pkg::IDX_IRQ_ENABLES, 8'h04);
    exp_pin = 1'b0;
    @(posedge pclk);
    adc_enable <= 1'b1;
    foreach (modes[i]) begin
      value = 16'h0100 + 16'($urandom % 32'hFE00);
      adc_seen = 0;
      run_mode(modes[i], value);
      exp_flag = modes[i] inside {[4'h8:4'hB]};
      if (modes[i] == 4'h8) begin
        exp_pin = 1'b1;
      end
      if (modes[i] == 4'h9) begin
        exp_pin = 1'b0;
      end
      check("pin level", 33'(exp_pin), 33'(pin_level));
      check("irq", 33'(exp_flag), 33'(irq));
      rd(tocu_pkg::IDX_IRQ_FLAGS, {5'h0, exp_flag, 2'b00});
      check("adc pulses", 33'(modes[i] == 4'hB), 33'(adc_seen));
      if (modes[i] == 4'hB) begin
        rd(tocu_pkg::IDX_COUNT_HIGH, 8'h00);
      end
      if (i == 1) begin
        wr(tocu_pkg::IDX_IRQ_ENABLES, 8'h00);
        @(negedge pclk);
        check("irq masked", 33'h0, 33'(irq));
        wr(tocu_pkg::IDX_IRQ_ENABLES, 8'h04);
      end
      if (i == 3) begin
        wr(tocu_pkg::IDX_UNIT_CONTROL, 8'h00);
        @(negedge pclk);
        check("pin forced", 33'h0, 33'(pin_level));
        exp_pin = 1'b0;
      end
    end
    @(posedge pclk);
    adc_enable <= 1'b0;
    adc_seen = 0;
    run_mode(4'hB, 16'h0200);
    check("adc pulses", 33'h0, 33'(adc_seen));
    rd(tocu_pkg::IDX_IRQ_FLAGS, 8'h04);
    run_mode(4'hC, 16'h0004);
    rd(tocu_pkg::IDX_IRQ_FLAGS, 8'h01);
    rd(tocu_pkg::IDX_UNIT_CONTROL, 8'h0C);
    wr(tocu_pkg::IDX_COUNT_LOW, 8'h00);
    wr(tocu_pkg::IDX_COUNT_HIGH, 8'h00);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h31);
    repeat (40) @(posedge pclk);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h00);
    rd(tocu_pkg::IDX_COUNT_LOW, 8'h05);
    wr(tocu_pkg::IDX_COUNT_LOW, 8'h00);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h03);
    repeat (30) @(posedge pclk);
    wr(tocu_pkg::IDX_TIMER1_CONTROL, 8'h00);
    @(negedge pclk);
    rd(tocu_pkg::IDX_COUNT_LOW, 8'(ext_seen));
    results();
  end
endmodule : test_timer1_output_compare_unit
